// [rtl/crf_core.sv]
// processor register file, stack select, control access, byte order
`timescale 1ns/1ps
module crf_core (
    // clock and reset
    input wire logic core_clk,
    input wire logic sys_rst,
    // register access from execution logic
    input wire crf_pkg::crf_breg_t rd_bsel,
    input wire crf_pkg::crf_wreg_t rd_wsel,
    input wire crf_pkg::crf_wr_t wr,
    input wire crf_pkg::crf_bit_t bit_req,
    input wire logic ex_fa,
    input wire logic ex_bw,
    // mode and exceptions
    input wire logic user_mode,
    input wire logic exc_entry,
    // control register access
    input wire crf_pkg::crf_ctl_t ctl,
    // interrupt vector
    input wire logic [7:0] vector_in,
    // memory addressing and byte order
    input wire logic [15:0] laddr,
    input wire logic xlate_en,
    input wire logic [23:0] mmu_paddr,
    input wire logic [15:0] st_word,
    input wire logic [7:0] mem_lo_in,
    input wire logic [7:0] mem_hi_in,
    // extension unit operands
    input wire crf_pkg::crf_opnd_t epu_type,
    input wire logic [3:0] epu_bcd_len,
    input wire logic [3:0] epu_idx,
    input wire logic [79:0] epu_opnd,
    input wire logic epu_in_valid,
    input wire logic epu_in_clear,
    input wire logic [7:0] epu_in_byte,
    // read data and bank state
    output logic [7:0] rd_byte_reg,
    output logic [15:0] rd_word_reg,
    output logic bit_zero_reg,
    output logic fa_alt_reg,
    output logic bw_alt_reg,
    output logic sp_sys_reg,
    // control register side
    output logic [7:0] ctl_index_reg,
    output logic ctl_ext_rd_reg,
    output logic ctl_ext_wr_reg,
    output logic [15:0] ctl_wdata_reg,
    output logic [15:0] ctl_rdata_reg,
    output logic ctl_fault_reg,
    // addressing results
    output logic [15:0] vec_addr_reg,
    output logic [23:0] paddr_reg,
    output logic space_user_reg,
    output logic aligned_reg,
    output logic [7:0] st_lo_reg,
    output logic [7:0] st_hi_reg,
    output logic [15:0] st_addr_hi_reg,
    output logic [15:0] ld_word_reg,
    // extension operand bytes
    output logic [7:0] epu_byte_reg,
    output logic [3:0] epu_len_reg,
    output logic epu_last_reg,
    output logic [79:0] epu_asm_reg
);

    logic [7:0] gp_reg [0:crf_pkg::CRF_GP_TOTAL-1];
    logic [7:0] acc_reg [0:1];
    logic [7:0] flg_reg [0:1];
    logic [15:0] ix_reg;
    logic [15:0] iy_reg;
    logic [15:0] ssp_reg;
    logic [15:0] usp_reg;
    logic [15:0] pc_reg;
    logic [7:0] vbase_reg;
    logic [7:0] rfsh_reg;

    logic sp_sys_w;
    // [RL6] exception entry forces system stack
    assign sp_sys_w = ~user_mode | exc_entry;

    // slot in active bank
    function automatic logic [3:0] gidx(input logic [3:0] n);
        gidx = bw_alt_reg ? 4'(n + crf_pkg::CRF_GP_PER_BANK) : n;
    endfunction : gidx

    function automatic logic [7:0] get_byte(input crf_pkg::crf_breg_t s);
        logic [7:0] v;
        v = crf_pkg::CRF_RST_BYTE;
        // [RL7] active bank byte
        if (s <= crf_pkg::CRF_L)
            v = gp_reg[gidx(4'(s))];
        else
        begin
            unique case (s)
                crf_pkg::CRF_F: v = flg_reg[fa_alt_reg];
                crf_pkg::CRF_A: v = acc_reg[fa_alt_reg];
                // [RL8] index halves
                crf_pkg::CRF_IXH: v = ix_reg[15:8];
                crf_pkg::CRF_IXL: v = ix_reg[7:0];
                crf_pkg::CRF_IYH: v = iy_reg[15:8];
                crf_pkg::CRF_IYL: v = iy_reg[7:0];
                crf_pkg::CRF_VB: v = vbase_reg;
                // [RL10] plain byte
                crf_pkg::CRF_RF: v = rfsh_reg;
                default: v = crf_pkg::CRF_RST_BYTE;
            endcase
        end
        get_byte = v;
    endfunction : get_byte

    function automatic logic [15:0] get_word(input crf_pkg::crf_wreg_t s);
        logic [15:0] v;
        v = crf_pkg::CRF_RST_WORD;
        unique case (s)
            // [RL7] fixed pairs
            crf_pkg::CRF_BC: v = {gp_reg[gidx(4'(crf_pkg::CRF_B))],
                                  gp_reg[gidx(4'(crf_pkg::CRF_C))]};
            crf_pkg::CRF_DE: v = {gp_reg[gidx(4'(crf_pkg::CRF_D))],
                                  gp_reg[gidx(4'(crf_pkg::CRF_E))]};
            crf_pkg::CRF_HL: v = {gp_reg[gidx(4'(crf_pkg::CRF_H))],
                                  gp_reg[gidx(4'(crf_pkg::CRF_L))]};
            crf_pkg::CRF_AF: v = {acc_reg[fa_alt_reg], flg_reg[fa_alt_reg]};
            crf_pkg::CRF_IX: v = ix_reg;
            crf_pkg::CRF_IY: v = iy_reg;
            // [RL4] mode picks pointer
            crf_pkg::CRF_SP: v = sp_sys_w ? ssp_reg : usp_reg;
            crf_pkg::CRF_PC: v = pc_reg;
        endcase
        get_word = v;
    endfunction : get_word

    // bit operations on byte registers
    logic [7:0] bit_src_w;
    logic [7:0] bit_mask_w;
    logic bit_wr_w;
    logic [7:0] bit_val_w;
    assign bit_src_w = get_byte(bit_req.sel);
    // [RL15] bit 0 is least significant
    assign bit_mask_w = crf_pkg::CRF_BIT0 << bit_req.idx;
    assign bit_wr_w = bit_req.en & ~wr.en
        & (bit_req.op != crf_pkg::CRF_BIT_TEST);
    assign bit_val_w = (bit_req.op == crf_pkg::CRF_BIT_SET)
        ? (bit_src_w | bit_mask_w) : (bit_src_w & ~bit_mask_w);

    // merged byte write
    logic bw_en_w;
    crf_pkg::crf_breg_t bw_sel_w;
    logic [7:0] bw_dat_w;
    logic ww_en_w;
    assign bw_en_w = (wr.en & ~wr.word) | bit_wr_w;
    assign bw_sel_w = wr.en ? wr.bsel : bit_req.sel;
    assign bw_dat_w = wr.en ? wr.data[7:0] : bit_val_w;
    assign ww_en_w = wr.en & wr.word;

    // control register decode
    logic [7:0] ctl_idx_w;
    logic ctl_ok_w;
    logic ctl_usp_w;
    // [RL12] index from port-address register
    assign ctl_idx_w = gp_reg[gidx(4'(crf_pkg::CRF_C))];
    // [RL11] privileged path only
    assign ctl_ok_w = ~user_mode;
    // [RL5] user pointer in control space
    assign ctl_usp_w = ctl_idx_w == crf_pkg::CRF_CTL_USP_IDX;

    // operand length and byte position
    logic [3:0] epu_len_w;
    logic [3:0] epu_pos_w;
    logic [7:0] epu_sel_w;
    always_comb
    begin
        epu_len_w = crf_pkg::CRF_LEN_4;
        unique case (epu_type)
            crf_pkg::CRF_INT32: epu_len_w = crf_pkg::CRF_LEN_4;
            crf_pkg::CRF_FP32: epu_len_w = crf_pkg::CRF_LEN_4;
            crf_pkg::CRF_INT64: epu_len_w = crf_pkg::CRF_LEN_8;
            // [RL21] eight-byte float
            crf_pkg::CRF_FP64: epu_len_w = crf_pkg::CRF_LEN_8;
            // [RL20] ten-byte float
            crf_pkg::CRF_FP80: epu_len_w = crf_pkg::CRF_LEN_10;
            // [RL22] at most ten bytes
            crf_pkg::CRF_BCD: epu_len_w =
                (epu_bcd_len == 4'h0 || epu_bcd_len > crf_pkg::CRF_LEN_10)
                ? crf_pkg::CRF_LEN_10 : epu_bcd_len;
            default: epu_len_w = crf_pkg::CRF_LEN_4;
        endcase
    end
    // [RL19] most significant byte at lowest address
    assign epu_pos_w = 4'(epu_len_w - crf_pkg::CRF_ONE - epu_idx);
    assign epu_sel_w = (epu_idx < epu_len_w)
        ? 8'(epu_opnd >> {epu_pos_w, 3'b000}) : crf_pkg::CRF_RST_BYTE;

    // general byte registers, both banks
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            for (int i = 0; i < crf_pkg::CRF_GP_TOTAL; i++)
                gp_reg[i] <= crf_pkg::CRF_RST_BYTE;
        end
        else if (bw_en_w && bw_sel_w <= crf_pkg::CRF_L)
            // [RL1] only the active copy
            gp_reg[gidx(4'(bw_sel_w))] <= bw_dat_w;
        else if (ww_en_w && wr.wsel <= crf_pkg::CRF_HL)
        begin
            gp_reg[gidx(4'({wr.wsel, 1'b0}))] <= wr.data[15:8];
            gp_reg[gidx(4'({wr.wsel, 1'b1}))] <= wr.data[7:0];
        end
    end

    // flag and accumulator pairs
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            acc_reg[0] <= crf_pkg::CRF_RST_BYTE;
            acc_reg[1] <= crf_pkg::CRF_RST_BYTE;
            flg_reg[0] <= crf_pkg::CRF_RST_BYTE;
            flg_reg[1] <= crf_pkg::CRF_RST_BYTE;
        end
        else if (bw_en_w && bw_sel_w == crf_pkg::CRF_A)
            acc_reg[fa_alt_reg] <= bw_dat_w;
        else if (bw_en_w && bw_sel_w == crf_pkg::CRF_F)
            flg_reg[fa_alt_reg] <= bw_dat_w;
        else if (ww_en_w && wr.wsel == crf_pkg::CRF_AF)
        begin
            acc_reg[fa_alt_reg] <= wr.data[15:8];
            flg_reg[fa_alt_reg] <= wr.data[7:0];
        end
    end

    // bank-select bits
    always_ff @(posedge core_clk)
    begin
        // [RL23] primary banks after reset
        if (sys_rst)
        begin
            fa_alt_reg <= crf_pkg::CRF_RST_BANK;
            bw_alt_reg <= crf_pkg::CRF_RST_BANK;
        end
        else
        begin
            // [RL2] exchanges toggle selects
            fa_alt_reg <= fa_alt_reg ^ ex_fa;
            bw_alt_reg <= bw_alt_reg ^ ex_bw;
        end
    end

    // index registers
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ix_reg <= crf_pkg::CRF_RST_WORD;
            iy_reg <= crf_pkg::CRF_RST_WORD;
        end
        else if (bw_en_w)
        begin
            // [RL8] byte halves writable
            if (bw_sel_w == crf_pkg::CRF_IXH) ix_reg[15:8] <= bw_dat_w;
            if (bw_sel_w == crf_pkg::CRF_IXL) ix_reg[7:0] <= bw_dat_w;
            if (bw_sel_w == crf_pkg::CRF_IYH) iy_reg[15:8] <= bw_dat_w;
            if (bw_sel_w == crf_pkg::CRF_IYL) iy_reg[7:0] <= bw_dat_w;
        end
        else if (ww_en_w)
        begin
            if (wr.wsel == crf_pkg::CRF_IX) ix_reg <= wr.data;
            if (wr.wsel == crf_pkg::CRF_IY) iy_reg <= wr.data;
        end
    end

    // stack pointers and program counter
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ssp_reg <= crf_pkg::CRF_RST_WORD;
            usp_reg <= crf_pkg::CRF_RST_WORD;
            pc_reg <= crf_pkg::CRF_RST_WORD;
        end
        else
        begin
            if (ww_en_w && wr.wsel == crf_pkg::CRF_PC) pc_reg <= wr.data;
            // [RL4] write to selected pointer
            if (ww_en_w && wr.wsel == crf_pkg::CRF_SP && sp_sys_w)
                ssp_reg <= wr.data;
            if (ctl.wr && ctl_ok_w && ctl_usp_w)
                usp_reg <= ctl.data;
            else if (ww_en_w && wr.wsel == crf_pkg::CRF_SP && !sp_sys_w)
                usp_reg <= wr.data;
        end
    end

    // vector base and refresh bytes
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            vbase_reg <= crf_pkg::CRF_RST_BYTE;
            rfsh_reg <= crf_pkg::CRF_RST_BYTE;
        end
        else if (bw_en_w)
        begin
            if (bw_sel_w == crf_pkg::CRF_VB) vbase_reg <= bw_dat_w;
            // [RL10] plain byte
            if (bw_sel_w == crf_pkg::CRF_RF) rfsh_reg <= bw_dat_w;
        end
    end

    // read ports and bank state
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            rd_byte_reg <= crf_pkg::CRF_RST_BYTE;
            rd_word_reg <= crf_pkg::CRF_RST_WORD;
            bit_zero_reg <= 1'b0;
            sp_sys_reg <= 1'b1;
        end
        else
        begin
            rd_byte_reg <= get_byte(rd_bsel);
            rd_word_reg <= get_word(rd_wsel);
            // [RL7] bit test zero flag
            bit_zero_reg <= ~|(bit_src_w & bit_mask_w);
            sp_sys_reg <= sp_sys_w;
        end
    end

    // control register access
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            ctl_index_reg <= crf_pkg::CRF_RST_BYTE;
            ctl_ext_rd_reg <= 1'b0;
            ctl_ext_wr_reg <= 1'b0;
            ctl_wdata_reg <= crf_pkg::CRF_RST_WORD;
            ctl_rdata_reg <= crf_pkg::CRF_RST_WORD;
            ctl_fault_reg <= 1'b0;
        end
        else
        begin
            ctl_index_reg <= ctl_idx_w;
            // [RL11] refused outside system mode
            ctl_ext_rd_reg <= ctl.rd & ctl_ok_w & ~ctl_usp_w;
            ctl_ext_wr_reg <= ctl.wr & ctl_ok_w & ~ctl_usp_w;
            ctl_fault_reg <= (ctl.rd | ctl.wr) & ~ctl_ok_w;
            ctl_wdata_reg <= ctl.data;
            // [RL5] user pointer readback
            if (ctl.rd && ctl_ok_w && ctl_usp_w)
                ctl_rdata_reg <= usp_reg;
        end
    end

    // address formation and word byte order
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            vec_addr_reg <= crf_pkg::CRF_RST_WORD;
            paddr_reg <= {crf_pkg::CRF_PAGE_ZERO, crf_pkg::CRF_RST_WORD};
            space_user_reg <= 1'b0;
            aligned_reg <= 1'b1;
            st_lo_reg <= crf_pkg::CRF_RST_BYTE;
            st_hi_reg <= crf_pkg::CRF_RST_BYTE;
            st_addr_hi_reg <= crf_pkg::CRF_RST_WORD;
            ld_word_reg <= crf_pkg::CRF_RST_WORD;
        end
        else
        begin
            // [RL9] table address
            vec_addr_reg <= {vbase_reg, vector_in};
            // [RL18] untranslated upper byte zero
            paddr_reg <= xlate_en ? mmu_paddr
                : {crf_pkg::CRF_PAGE_ZERO, laddr};
            // [RL13] descriptor set select
            space_user_reg <= user_mode;
            // [RL16] even address aligned
            aligned_reg <= ~laddr[0];
            // [RL17] low byte at lower address
            st_lo_reg <= st_word[7:0];
            st_hi_reg <= st_word[15:8];
            // [RL14] wraps within 64K
            st_addr_hi_reg <= 16'(laddr + crf_pkg::CRF_NEXT_BYTE);
            ld_word_reg <= {mem_hi_in, mem_lo_in};
        end
    end

    // extension operand serialise and assemble
    always_ff @(posedge core_clk)
    begin
        if (sys_rst)
        begin
            epu_byte_reg <= crf_pkg::CRF_RST_BYTE;
            epu_len_reg <= crf_pkg::CRF_LEN_4;
            epu_last_reg <= 1'b0;
            epu_asm_reg <= crf_pkg::CRF_RST_OPND;
        end
        else
        begin
            // [RL19] big-endian byte order
            epu_byte_reg <= epu_sel_w;
            epu_len_reg <= epu_len_w;
            epu_last_reg <= epu_idx == 4'(epu_len_w - crf_pkg::CRF_ONE);
            if (epu_in_clear)
                epu_asm_reg <= crf_pkg::CRF_RST_OPND;
            else if (epu_in_valid)
                epu_asm_reg <= {epu_asm_reg[71:0], epu_in_byte};
        end
    end

endmodule : crf_core

// [pkg/crf_pkg.sv]
// constants and types for the processor register file block
// Operation
// [RL1] two copies of flag/acc and byte registers
// [RL2] select bits steer banks, exchanges toggle them
// [RL3] both bank-select bits visible to jumps
// [RL4] stack pointer follows user/system mode bit
// [RL5] user stack pointer reachable as control register
// [RL6] exceptions and system calls use system pointer
// [RL7] byte registers, bit access, three word pairs
// [RL8] index registers as word or halves
// [RL9] vector base plus vector forms table address
// [RL10] refresh register is plain read/write byte
// [RL11] control registers only via load-control instruction
// [RL12] control index is port-address register, untranslated
// [RL13] mode bit selects page descriptor set
// [RL14] 64K byte-addressed logical space per mode
// [RL15] bits numbered right to left from 0
// [RL16] operand at lowest address, even word aligned
// [RL17] word low byte at lower address
// [RL18] untranslated physical address has upper byte zero
// [RL19] extension integers most significant byte first
// [RL20] 80-bit float sign/exponent first, fraction descending
// [RL21] 64-bit float sign/exponent first, fraction descending
// [RL22] decimal strings up to ten bytes, sign first
// [RL23] reset clears both bank-select bits
package crf_pkg;

    typedef enum logic [3:0] {
        CRF_B, CRF_C, CRF_D, CRF_E, CRF_H, CRF_L, CRF_F, CRF_A,
        CRF_IXH, CRF_IXL, CRF_IYH, CRF_IYL, CRF_VB, CRF_RF
    } crf_breg_t;

    typedef enum logic [2:0] {
        CRF_BC, CRF_DE, CRF_HL, CRF_AF, CRF_IX, CRF_IY, CRF_SP, CRF_PC
    } crf_wreg_t;

    typedef enum logic [2:0] {
        CRF_INT32, CRF_INT64, CRF_FP32, CRF_FP64, CRF_FP80, CRF_BCD
    } crf_opnd_t;

    typedef enum logic [1:0] {
        CRF_BIT_TEST, CRF_BIT_SET, CRF_BIT_RES
    } crf_bitop_t;

    typedef struct packed {
        logic en;
        logic word;
        crf_breg_t bsel;
        crf_wreg_t wsel;
        logic [15:0] data;
    } crf_wr_t;

    typedef struct packed {
        logic en;
        crf_bitop_t op;
        crf_breg_t sel;
        logic [2:0] idx;
    } crf_bit_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] data;
    } crf_ctl_t;

    localparam logic [3:0] CRF_GP_PER_BANK = 4'h6;
    localparam int CRF_GP_TOTAL = 12;
    localparam logic CRF_RST_BANK = 1'b0;
    localparam logic [7:0] CRF_RST_BYTE = 8'h00;
    localparam logic [15:0] CRF_RST_WORD = 16'h0000;
    localparam logic [7:0] CRF_CTL_USP_IDX = 8'h08;
    localparam logic [7:0] CRF_PAGE_ZERO = 8'h00;
    localparam logic [15:0] CRF_NEXT_BYTE = 16'h0001;
    localparam logic [7:0] CRF_BIT0 = 8'h01;
    localparam logic [3:0] CRF_LEN_4 = 4'h4;
    localparam logic [3:0] CRF_LEN_8 = 4'h8;
    localparam logic [3:0] CRF_LEN_10 = 4'hA;
    localparam logic [3:0] CRF_ONE = 4'h1;
    localparam logic [79:0] CRF_RST_OPND = 80'h0;

endpackage : crf_pkg

// [verif/crf_core_sva.sv]
// concurrent checks on the register file block ports
`timescale 1ns/1ps
module crf_core_sva (
    // clock and reset
    input logic core_clk,
    input logic sys_rst,
    // requests
    input logic ex_fa,
    input logic ex_bw,
    input logic user_mode,
    input logic exc_entry,
    input crf_pkg::crf_ctl_t ctl,
    input logic [7:0] vector_in,
    input logic [15:0] laddr,
    input logic xlate_en,
    input logic [15:0] st_word,
    input logic [7:0] mem_lo_in,
    input logic [7:0] mem_hi_in,
    input crf_pkg::crf_opnd_t epu_type,
    input logic [3:0] epu_idx,
    input logic [79:0] epu_opnd,
    // results
    input logic fa_alt_reg,
    input logic bw_alt_reg,
    input logic sp_sys_reg,
    input logic ctl_ext_rd_reg,
    input logic ctl_ext_wr_reg,
    input logic ctl_fault_reg,
    input logic [15:0] vec_addr_reg,
    input logic [23:0] paddr_reg,
    input logic space_user_reg,
    input logic aligned_reg,
    input logic [7:0] st_lo_reg,
    input logic [7:0] st_hi_reg,
    input logic [15:0] ld_word_reg,
    input logic [7:0] epu_byte_reg,
    input logic [3:0] epu_len_reg
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (sys_rst);
    sequence s_user_ctl;
        user_mode && (ctl.rd || ctl.wr);
    endsequence
    sequence s_refused;
        ctl_fault_reg && !ctl_ext_rd_reg && !ctl_ext_wr_reg;
    endsequence
    a_fa_toggle: assert property (
        ##1 fa_alt_reg == ($past(fa_alt_reg) ^ $past(ex_fa)))
        else $error("flag bank select wrong");
    a_bw_toggle: assert property (
        ##1 bw_alt_reg == ($past(bw_alt_reg) ^ $past(ex_bw)))
        else $error("byte bank select wrong");
    a_sp_select: assert property (
        ##1 sp_sys_reg == (!$past(user_mode) || $past(exc_entry)))
        else $error("stack pointer select wrong");
    a_space_mode: assert property (
        ##1 space_user_reg == $past(user_mode))
        else $error("descriptor set wrong");
    a_align_even: assert property (
        (laddr[0] |=> !aligned_reg) and (!laddr[0] |=> aligned_reg))
        else $error("alignment flag wrong");
    a_store_order: assert property (
        ##1 {st_hi_reg, st_lo_reg} == $past(st_word))
        else $error("store byte order wrong");
    a_load_order: assert property (
        ##1 ld_word_reg == {$past(mem_hi_in), $past(mem_lo_in)})
        else $error("load byte order wrong");
    a_phys_plain: assert property (
        !xlate_en |=> paddr_reg == {8'h00, $past(laddr)})
        else $error("untranslated address wrong");
    a_vec_low: assert property (
        ##1 vec_addr_reg[7:0] == $past(vector_in))
        else $error("vector byte wrong");
    a_ctl_refuse: assert property (
        s_user_ctl |=> s_refused)
        else $error("user control access not refused");
    a_fp80_len: assert property (
        epu_type == crf_pkg::CRF_FP80 |=> epu_len_reg == 4'hA)
        else $error("long float length wrong");
    a_int_msb: assert property (
        epu_type == crf_pkg::CRF_INT64 && epu_idx == 4'h0
        |=> epu_byte_reg == $past(epu_opnd[63:56]))
        else $error("integer first byte wrong");
endmodule : crf_core_sva

bind crf_core crf_core_sva u_crf_core_sva (.*);

// [verif/crf_exec_model.sv]
// execution-side model issuing bank exchanges and mode changes
`timescale 1ns/1ps
module crf_exec_model (
    // clock and reset
    input logic core_clk,
    input logic sys_rst,
    // controls toward the register file
    output logic ex_fa,
    output logic ex_bw,
    output logic user_mode,
    output logic exc_entry,
    // bank state the core should show
    output logic fa_exp,
    output logic bw_exp
);
    initial {ex_fa, ex_bw, user_mode, exc_entry} = 4'h0;
    always_ff @(posedge core_clk)
    begin
        fa_exp <= sys_rst ? 1'b0 : fa_exp ^ ex_fa;
        bw_exp <= sys_rst ? 1'b0 : bw_exp ^ ex_bw;
    end
    // one-cycle pulse after gap idle cycles
    task automatic xchg(input logic fa, input logic bw, input int gap);
        repeat (gap) @(posedge core_clk) #1;
        ex_fa = fa;
        ex_bw = bw;
        @(posedge core_clk) #1;
        ex_fa = 1'b0;
        ex_bw = 1'b0;
    endtask : xchg
    task automatic set_mode(input logic usr, input logic exc);
        user_mode = usr;
        exc_entry = exc;
    endtask : set_mode
endmodule : crf_exec_model

// [verif/crf_core_tb.sv]
// self-checking bench for the register file block
`timescale 1ns/1ps
module crf_core_tb;
    logic core_clk, sys_rst, ex_fa, ex_bw, user_mode, exc_entry, xlate_en;
    logic fa_exp, bw_exp, fa_alt_reg, bw_alt_reg, sp_sys_reg, bit_zero_reg;
    logic ctl_ext_wr_reg, ctl_fault_reg, space_user_reg, aligned_reg;
    crf_pkg::crf_breg_t rd_bsel;
    crf_pkg::crf_wreg_t rd_wsel;
    crf_pkg::crf_wr_t wr;
    crf_pkg::crf_bit_t bit_req;
    crf_pkg::crf_ctl_t ctl;
    crf_pkg::crf_opnd_t epu_type;
    logic [7:0] vector_in, mem_lo_in, mem_hi_in, rd_byte_reg, ctl_index_reg;
    logic [7:0] st_lo_reg, st_hi_reg, epu_byte_reg;
    logic [15:0] laddr, st_word, rd_word_reg, ctl_wdata_reg, ctl_rdata_reg;
    logic [15:0] vec_addr_reg, st_addr_hi_reg, ld_word_reg, w0, w1;
    logic [23:0] mmu_paddr, paddr_reg;
    logic [79:0] epu_opnd;
    logic [3:0] epu_bcd_len, epu_idx, epu_len_reg;
    int n_errors = 0, tests_run = 0;
    logic [3:0] lens [7] = '{4'h4, 4'h8, 4'h4, 4'h8, 4'hA, 4'h3, 4'hA};

    crf_core u_crf_core (
        .core_clk, .sys_rst, .rd_bsel, .rd_wsel, .wr, .bit_req, .ex_fa,
        .ex_bw, .user_mode, .exc_entry, .ctl, .vector_in, .laddr,
        .xlate_en, .mmu_paddr, .st_word, .mem_lo_in, .mem_hi_in,
        .epu_type, .epu_bcd_len, .epu_idx, .epu_opnd,
        .epu_in_valid(1'b0), .epu_in_clear(1'b0), .epu_in_byte(8'h00),
        .rd_byte_reg, .rd_word_reg, .bit_zero_reg, .fa_alt_reg,
        .bw_alt_reg, .sp_sys_reg, .ctl_index_reg, .ctl_ext_rd_reg(),
        .ctl_ext_wr_reg, .ctl_wdata_reg, .ctl_rdata_reg, .ctl_fault_reg,
        .vec_addr_reg, .paddr_reg, .space_user_reg, .aligned_reg,
        .st_lo_reg, .st_hi_reg, .st_addr_hi_reg, .ld_word_reg,
        .epu_byte_reg, .epu_len_reg, .epu_last_reg(), .epu_asm_reg()
    );
    crf_exec_model u_crf_exec_model (
        .core_clk, .sys_rst, .ex_fa, .ex_bw, .user_mode, .exc_entry,
        .fa_exp, .bw_exp
    );

    initial
    begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic step;
        @(posedge core_clk) #1;
    endtask : step
    task automatic chk(input logic [79:0] got, input logic [79:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
        end
    endtask : chk
    task automatic tally_and_finish;
        $display("checks %0d errors %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : tally_and_finish
    task automatic wr_b(input crf_pkg::crf_breg_t s, input logic [7:0] d);
        wr = '{1'b1, 1'b0, s, crf_pkg::CRF_BC, {8'h00, d}};
        step;
        wr.en = 1'b0;
    endtask : wr_b
    task automatic wr_w(input crf_pkg::crf_wreg_t s, input logic [15:0] d);
        wr = '{1'b1, 1'b1, crf_pkg::CRF_B, s, d};
        step;
        wr.en = 1'b0;
    endtask : wr_w
    task automatic rd_b(input crf_pkg::crf_breg_t s, input logic [7:0] e);
        rd_bsel = s;
        step;
        chk(rd_byte_reg, e);
    endtask : rd_b
    task automatic rd_w(input crf_pkg::crf_wreg_t s, input logic [15:0] e);
        rd_wsel = s;
        step;
        chk(rd_word_reg, e);
    endtask : rd_w
    task automatic ctl_op(input logic r, input logic w, input logic [15:0] d);
        ctl = '{r, w, d};
        step;
        ctl = '0;
    endtask : ctl_op
    function automatic logic [7:0] exp_byte(input logic [79:0] op,
            input logic [3:0] len, input logic [3:0] idx);
        return (idx >= len) ? 8'h00 : op[8 * (len - 1 - idx) +: 8];
    endfunction : exp_byte

    initial
    begin
        #2000000;
        n_errors++;
        tally_and_finish;
    end

    initial
    begin
        sys_rst = 1'b1;
        rd_bsel = crf_pkg::CRF_B;
        rd_wsel = crf_pkg::CRF_BC;
        epu_type = crf_pkg::CRF_INT32;
        {wr, bit_req, ctl, vector_in, laddr, xlate_en, mmu_paddr, st_word,
            mem_lo_in, mem_hi_in, epu_bcd_len, epu_idx, epu_opnd} = '0;
        void'($urandom(12));
        repeat (4) @(posedge core_clk);
        #1;
        sys_rst = 1'b0;
        chk({fa_alt_reg, bw_alt_reg, sp_sys_reg}, 3'h1);
        w0 = 16'($urandom);
        w1 = 16'($urandom);
        wr_b(crf_pkg::CRF_A, w0[7:0]);
        u_crf_exec_model.xchg(1'b1, 1'b0, 0);
        chk(fa_alt_reg, fa_exp);
        wr_b(crf_pkg::CRF_A, w1[7:0]);
        rd_b(crf_pkg::CRF_A, w1[7:0]);
        u_crf_exec_model.xchg(1'b1, 1'b0, 2);
        rd_b(crf_pkg::CRF_A, w0[7:0]);
        wr_w(crf_pkg::CRF_BC, w0);
        u_crf_exec_model.xchg(1'b0, 1'b1, 0);
        wr_w(crf_pkg::CRF_BC, w1);
        rd_b(crf_pkg::CRF_B, w1[15:8]);
        u_crf_exec_model.xchg(1'b1, 1'b1, 1);
        chk({fa_alt_reg, bw_alt_reg}, {fa_exp, bw_exp});
        rd_w(crf_pkg::CRF_BC, w0);
        rd_b(crf_pkg::CRF_C, w0[7:0]);
        bit_req = '{1'b1, crf_pkg::CRF_BIT_TEST, crf_pkg::CRF_B, 3'h0};
        step;
        chk(bit_zero_reg, !w0[8]);
        wr_w(crf_pkg::CRF_IX, w1);
        rd_b(crf_pkg::CRF_IXH, w1[15:8]);
        rd_b(crf_pkg::CRF_IXL, w1[7:0]);
        wr_b(crf_pkg::CRF_RF, w0[15:8]);
        rd_b(crf_pkg::CRF_RF, w0[15:8]);
        wr_b(crf_pkg::CRF_VB, w1[15:8]);
        vector_in = w0[7:0];
        step;
        chk(vec_addr_reg, {w1[15:8], w0[7:0]});
        wr_b(crf_pkg::CRF_C, 8'h08);
        ctl_op(1'b0, 1'b1, w0);
        step;
        ctl_op(1'b1, 1'b0, 16'h0000);
        chk(ctl_rdata_reg, w0);
        u_crf_exec_model.set_mode(1'b1, 1'b0);
        rd_w(crf_pkg::CRF_SP, w0);
        ctl_op(1'b0, 1'b1, w1);
        chk({ctl_fault_reg, ctl_ext_wr_reg}, 2'h2);
        u_crf_exec_model.set_mode(1'b1, 1'b1);
        step;
        chk(sp_sys_reg, 1'b1);
        u_crf_exec_model.set_mode(1'b0, 1'b0);
        wr_b(crf_pkg::CRF_C, 8'h20);
        ctl_op(1'b0, 1'b1, w1);
        chk(ctl_index_reg, 8'h20);
        chk({ctl_ext_wr_reg, ctl_wdata_reg}, {1'b1, w1});
        for (int i = 0; i < 40; i++)
        begin
            laddr = (i == 0) ? 16'hFFFF : 16'($urandom);
            xlate_en = (i > 1) && 1'($urandom);
            mmu_paddr = 24'($urandom);
            st_word = 16'($urandom);
            {mem_hi_in, mem_lo_in} = 16'($urandom);
            u_crf_exec_model.set_mode(1'($urandom), 1'($urandom));
            step;
            chk(paddr_reg, xlate_en ? mmu_paddr : {8'h00, laddr});
            chk({st_hi_reg, st_lo_reg}, st_word);
            chk(ld_word_reg, {mem_hi_in, mem_lo_in});
            chk(st_addr_hi_reg, 16'(laddr + 16'h0001));
            chk(aligned_reg, !laddr[0]);
            chk(space_user_reg, user_mode);
            chk(sp_sys_reg, !user_mode || exc_entry);
        end
        for (int t = 0; t < 7; t++)
        begin
            epu_type = crf_pkg::crf_opnd_t'((t > 5) ? 5 : t);
            epu_bcd_len = (t == 5) ? 4'h3 : 4'hF;
            epu_opnd = {16'($urandom), $urandom, $urandom};
            for (int k = 0; k < 11; k++)
            begin
                epu_idx = 4'(k);
                step;
                chk(epu_byte_reg, exp_byte(epu_opnd, lens[t], epu_idx));
            end
            chk(epu_len_reg, lens[t]);
        end
        tally_and_finish;
    end
endmodule : crf_core_tb
